// ---- rtl/can_bit_timing_config.sv ----
// Operation
// - Timing registers writable only under reset request; other writes are refused.
// - Quantum lasts two clocks times prescaler field plus one.
// - One resynchronization moves a bit by at most jump width plus one quanta.
// - Only the first recessive-to-dominant edge after a bit's sync quantum triggers a resynchronization; others are dropped.
// - First segment lasts first-segment field plus one quanta.
// - Second segment lasts second-segment field plus one quanta.
// - Sampling-mode bit selects three samples or one per sample point.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
module can_bit_timing_config (
    input  wire logic        i_clock,
    input  wire logic        i_rst_b,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_can_rx,
    output logic             o_quantum_tick,
    output logic             o_bit_start,
    output logic             o_sample_point,
    output logic             o_rx_bit
);

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic [1:0] rst_sync;
    logic       rst_b;

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_b = rst_sync[1];

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    can_bit_timing_pkg::prescale_jump_s     prescale_jump;
    can_bit_timing_pkg::segments_sampling_s segments;
    can_bit_timing_pkg::phase_e             phase;
    logic        reset_req;
    logic        rx_level;
    logic        apb_setup;
    logic        apb_commit;
    logic        timing_sel;
    logic        mapped;
    logic        refused;
    logic [31:0] read_value;

    assign apb_setup  = i_psel && !i_penable;
    assign apb_commit = i_psel && i_penable && o_pready;
    assign timing_sel = (i_paddr == can_bit_timing_pkg::PRESCALE_JUMP_ADDR)
                     || (i_paddr == can_bit_timing_pkg::SEGMENTS_ADDR);
    assign mapped     = timing_sel || (i_paddr == can_bit_timing_pkg::CTRL_ADDR)
                     || (i_paddr == can_bit_timing_pkg::STAT_ADDR);
    assign refused    = i_pwrite && timing_sel && !reset_req;

    always_comb begin
        read_value = '0;
        unique case (i_paddr)
            can_bit_timing_pkg::CTRL_ADDR:
                read_value[can_bit_timing_pkg::CTRL_RESET_REQ_BIT] = reset_req;
            can_bit_timing_pkg::STAT_ADDR: begin
                read_value[can_bit_timing_pkg::STAT_RX_BIT]   = o_rx_bit;
                read_value[can_bit_timing_pkg::STAT_RX_LEVEL] = rx_level;
                read_value[can_bit_timing_pkg::STAT_PHASE_HI:
                           can_bit_timing_pkg::STAT_PHASE_LO] = 2'(phase);
            end
            can_bit_timing_pkg::PRESCALE_JUMP_ADDR: read_value[7:0] = prescale_jump;
            can_bit_timing_pkg::SEGMENTS_ADDR:      read_value[7:0] = segments;
            default:                                read_value = '0;
        endcase
    end

    // Answer is registered in the setup cycle, so every access has exactly one wait-free
    // access phase; status is a snapshot from the setup cycle.
    always_ff @(posedge i_clock or negedge rst_b) begin
        if (!rst_b) begin
            o_pready  <= 1'b0;
            o_prdata  <= '0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready  <= apb_setup;
            o_prdata  <= (apb_setup && !i_pwrite) ? read_value : '0;
            o_pslverr <= apb_setup && (!mapped || refused);
        end
    end

    always_ff @(posedge i_clock or negedge rst_b) begin
        if (!rst_b) begin
            reset_req <= can_bit_timing_pkg::CTRL_RESET_REQ_RST;
        end else if (apb_commit && i_pwrite && i_paddr == can_bit_timing_pkg::CTRL_ADDR) begin
            reset_req <= i_pwdata[can_bit_timing_pkg::CTRL_RESET_REQ_BIT];
        end
    end

    always_ff @(posedge i_clock or negedge rst_b) begin
        if (!rst_b) begin
            prescale_jump <= can_bit_timing_pkg::PRESCALE_JUMP_RST;
            segments      <= can_bit_timing_pkg::SEGMENTS_RST;
        end else if (apb_commit && i_pwrite && reset_req) begin
            if (i_paddr == can_bit_timing_pkg::PRESCALE_JUMP_ADDR) begin
                prescale_jump <= i_pwdata[7:0];
            end
            if (i_paddr == can_bit_timing_pkg::SEGMENTS_ADDR) begin
                segments <= i_pwdata[7:0];
            end
        end
    end

    // ----------------------------------------
    // Receive pin filter
    // ----------------------------------------
    logic [2:0] rx_sync;
    logic       rx_prev;
    logic       edge_fall;

    always_ff @(posedge i_clock or negedge rst_b) begin
        if (!rst_b) begin
            rx_sync  <= 3'b111;
            rx_level <= 1'b1;
            rx_prev  <= 1'b1;
        end else begin
            rx_sync <= {rx_sync[1:0], i_can_rx};
            if (rx_sync[1] == rx_sync[2]) begin
                rx_level <= rx_sync[2];
            end
            rx_prev <= rx_level;
        end
    end
    assign edge_fall = rx_prev && !rx_level;

    // ----------------------------------------
    // Quantum clock
    // ----------------------------------------
    quantum_prescaler #(
        .PRESCALE_W (6)
    ) u_prescaler (
        .i_clock    (i_clock),
        .i_rst_b    (rst_b),
        .i_hold     (reset_req),
        .i_prescale (prescale_jump.quantum_prescaler_field),
        .o_tick     (o_quantum_tick)
    );

    // ----------------------------------------
    // Bit phase engine
    // ----------------------------------------
    logic [4:0] count;
    logic [4:0] seg_len;
    logic [4:0] jump;
    logic [4:0] seg1_len;
    logic [4:0] seg2_len;
    logic [4:0] late_err;
    logic [4:0] early_err;
    logic       edge_pend;
    logic       resync_done;
    logic       resync_now;
    logic [2:0] history;

    assign jump       = 5'(prescale_jump.jump_width_field) + 5'h01;
    assign seg1_len   = 5'(segments.first_segment_field) + 5'h01;
    assign seg2_len   = 5'(segments.second_segment_field) + 5'h01;
    assign late_err   = count + 5'h01;
    assign early_err  = seg_len - count;
    assign resync_now = edge_pend && !resync_done;

    // An edge seen in the same cycle as the consuming tick stays pending
    always_ff @(posedge i_clock or negedge rst_b) begin
        if (!rst_b) begin
            edge_pend <= 1'b0;
        end else if (reset_req) begin
            edge_pend <= 1'b0;
        end else if (edge_fall) begin
            edge_pend <= 1'b1;
        end else if (o_quantum_tick) begin
            edge_pend <= 1'b0;
        end
    end

    always_ff @(posedge i_clock or negedge rst_b) begin
        if (!rst_b) begin
            phase       <= can_bit_timing_pkg::PH_SYNC;
            count       <= '0;
            seg_len     <= '0;
            resync_done <= 1'b0;
            o_bit_start <= 1'b0;
            o_sample_point <= 1'b0;
        end else if (reset_req) begin
            phase       <= can_bit_timing_pkg::PH_SYNC;
            count       <= '0;
            seg_len     <= '0;
            resync_done <= 1'b0;
            o_bit_start <= 1'b0;
            o_sample_point <= 1'b0;
        end else begin
            o_bit_start    <= 1'b0;
            o_sample_point <= 1'b0;
            if (o_quantum_tick) begin
                unique case (phase)
                    can_bit_timing_pkg::PH_SYNC: begin
                        phase       <= can_bit_timing_pkg::PH_SEG1;
                        count       <= '0;
                        seg_len     <= seg1_len;
                        resync_done <= 1'b0;
                    end
                    can_bit_timing_pkg::PH_SEG1: begin
                        if (resync_now) begin
                            seg_len     <= seg_len + ((late_err < jump) ? late_err : jump);
                            count       <= count + 5'h01;
                            resync_done <= 1'b1;
                        end else if (late_err >= seg_len) begin
                            phase          <= can_bit_timing_pkg::PH_SEG2;
                            count          <= '0;
                            seg_len        <= seg2_len;
                            o_sample_point <= 1'b1;
                        end else begin
                            count <= count + 5'h01;
                        end
                    end
                    can_bit_timing_pkg::PH_SEG2: begin
                        if (resync_now && early_err <= jump) begin
                            // Edge stands in for the sync quantum of the next bit
                            phase       <= can_bit_timing_pkg::PH_SEG1;
                            count       <= '0;
                            seg_len     <= seg1_len;
                            resync_done <= 1'b1;
                            o_bit_start <= 1'b1;
                        end else if (resync_now) begin
                            seg_len     <= seg_len - jump;
                            resync_done <= 1'b1;
                            if (seg_len - jump <= late_err) begin
                                phase       <= can_bit_timing_pkg::PH_SYNC;
                                o_bit_start <= 1'b1;
                            end else begin
                                count <= count + 5'h01;
                            end
                        end else if (late_err >= seg_len) begin
                            phase       <= can_bit_timing_pkg::PH_SYNC;
                            o_bit_start <= 1'b1;
                        end else begin
                            count <= count + 5'h01;
                        end
                    end
                    default: begin
                        phase <= can_bit_timing_pkg::PH_SYNC;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // Sampling
    // ----------------------------------------
    always_ff @(posedge i_clock or negedge rst_b) begin
        if (!rst_b) begin
            history  <= 3'b111;
            o_rx_bit <= 1'b1;
        end else if (o_quantum_tick) begin
            history <= {history[1:0], rx_level};
            if (phase == can_bit_timing_pkg::PH_SEG1 && !resync_now && late_err >= seg_len) begin
                if (segments.sampling_mode_bit) begin
                    o_rx_bit <= (history[1] & history[0]) | (history[1] & rx_level)
                              | (history[0] & rx_level);
                end else begin
                    o_rx_bit <= rx_level;
                end
            end
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    logic [7:0] gap;
    logic       seen_tick;

    always_ff @(posedge i_clock or negedge rst_b) begin
        if (!rst_b) begin
            gap       <= '0;
            seen_tick <= 1'b0;
        end else begin
            gap       <= o_quantum_tick ? 8'h01 : gap + 8'h01;
            seen_tick <= !reset_req && (seen_tick || o_quantum_tick);
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!rst_b);

    property p_refused_write;
        apb_commit && refused |=> $stable(prescale_jump) && $stable(segments);
    endproperty
    a_refused_write: assert property (p_refused_write) else $error("timing write taken");

    property p_refused_error;
        apb_setup && refused |=> o_pready && o_pslverr;
    endproperty
    a_refused_error: assert property (p_refused_error) else $error("refused write no error");

    property p_quantum_period;
        o_quantum_tick && seen_tick && !reset_req |->
            gap == 8'(({2'b00, prescale_jump.quantum_prescaler_field} + 8'h01) * 2);
    endproperty
    a_quantum_period: assert property (p_quantum_period) else $error("quantum period wrong");

    property p_late_limit;
        o_quantum_tick && phase == can_bit_timing_pkg::PH_SEG1 && resync_now && !reset_req
            |=> (seg_len - $past(seg_len)) <= jump && seg_len > $past(seg_len);
    endproperty
    a_late_limit: assert property (p_late_limit) else $error("lengthening too large");

    property p_edge_served;
        edge_pend && !reset_req |-> ##[0:128] o_quantum_tick;
    endproperty
    a_edge_served: assert property (p_edge_served) else $error("edge never served");

    property p_seg1_start;
        o_quantum_tick && phase == can_bit_timing_pkg::PH_SYNC && !reset_req
            |=> phase == can_bit_timing_pkg::PH_SEG1 && seg_len == seg1_len && count == '0;
    endproperty
    a_seg1_start: assert property (p_seg1_start) else $error("first segment load wrong");

    property p_seg2_start;
        o_sample_point |-> phase == can_bit_timing_pkg::PH_SEG2 && seg_len == seg2_len;
    endproperty
    a_seg2_start: assert property (p_seg2_start) else $error("second segment load wrong");

    property p_single_sample;
        o_sample_point && !segments.sampling_mode_bit |-> o_rx_bit == $past(rx_level);
    endproperty
    a_single_sample: assert property (p_single_sample) else $error("single sample wrong");

    property p_majority;
        o_sample_point && segments.sampling_mode_bit |-> o_rx_bit ==
            (($past(history[1]) & $past(history[0])) | ($past(history[1]) & $past(rx_level))
            | ($past(history[0]) & $past(rx_level)));
    endproperty
    a_majority: assert property (p_majority) else $error("majority vote wrong");

    property p_seg2_end;
        o_quantum_tick && phase == can_bit_timing_pkg::PH_SEG2 && !resync_now && !reset_req
            && late_err >= seg_len |=> phase == can_bit_timing_pkg::PH_SYNC && o_bit_start;
    endproperty
    a_seg2_end: assert property (p_seg2_end) else $error("bit end wrong");

    property p_cov_triple;
        o_sample_point && segments.sampling_mode_bit;
    endproperty
    c_cov_triple: cover property (p_cov_triple);

    property p_cov_early;
        o_quantum_tick && phase == can_bit_timing_pkg::PH_SEG2 && resync_now;
    endproperty
    c_cov_early: cover property (p_cov_early);

    property p_cov_refused;
        apb_commit && refused;
    endproperty
    c_cov_refused: cover property (p_cov_refused);

endmodule // can_bit_timing_config

// ---- rtl/can_bit_timing_pkg.sv ----
package can_bit_timing_pkg;

    // ----------------------------------------
    // Register map: printed offsets are word indices
    // ----------------------------------------
    localparam int         ADDR_W           = 12;
    localparam logic [11:0] CTRL_IDX        = 12'h000;
    localparam logic [11:0] STAT_IDX        = 12'h001;
    localparam logic [11:0] PRESCALE_JUMP_IDX = 12'h006;
    localparam logic [11:0] SEGMENTS_IDX    = 12'h007;
    localparam logic [11:0] CTRL_ADDR       = 12'(CTRL_IDX * 4);
    localparam logic [11:0] STAT_ADDR       = 12'(STAT_IDX * 4);
    localparam logic [11:0] PRESCALE_JUMP_ADDR = 12'(PRESCALE_JUMP_IDX * 4);
    localparam logic [11:0] SEGMENTS_ADDR   = 12'(SEGMENTS_IDX * 4);

    // ----------------------------------------
    // Field layouts and reset values
    // ----------------------------------------
    localparam int         CTRL_RESET_REQ_BIT = 0;
    localparam logic       CTRL_RESET_REQ_RST = 1'b1;
    localparam int         STAT_RX_BIT      = 0;
    localparam int         STAT_RX_LEVEL    = 1;
    localparam int         STAT_PHASE_LO    = 2;
    localparam int         STAT_PHASE_HI    = 3;

    typedef struct packed {
        logic [1:0] jump_width_field;
        logic [5:0] quantum_prescaler_field;
    } prescale_jump_s;

    typedef struct packed {
        logic       sampling_mode_bit;
        logic [2:0] second_segment_field;
        logic [3:0] first_segment_field;
    } segments_sampling_s;

    localparam prescale_jump_s     PRESCALE_JUMP_RST = '0;
    localparam segments_sampling_s SEGMENTS_RST      = '0;

    // ----------------------------------------
    // Bit phases
    // ----------------------------------------
    typedef enum logic [1:0] {
        PH_SYNC,
        PH_SEG1,
        PH_SEG2
    } phase_e;

endpackage

// ---- rtl/quantum_prescaler.sv ----
`timescale 1ns/1ps
module quantum_prescaler #(
    parameter int PRESCALE_W = 6
) (
    input  wire logic                  i_clock,
    input  wire logic                  i_rst_b,
    input  wire logic                  i_hold,
    input  wire logic [PRESCALE_W-1:0] i_prescale,
    output logic                       o_tick
);

    logic [PRESCALE_W:0] count;
    logic [PRESCALE_W:0] limit;

    // Period is two clocks per prescale step, so the limit is 2*p+1
    assign limit = {i_prescale, 1'b1};

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            count  <= '0;
            o_tick <= 1'b0;
        end else if (i_hold) begin
            count  <= '0;
            o_tick <= 1'b0;
        end else if (count == limit) begin
            count  <= '0;
            o_tick <= 1'b1;
        end else begin
            count  <= count + 1'b1;
            o_tick <= 1'b0;
        end
    end

endmodule // quantum_prescaler

// ---- verification/can_bus_model.sv ----
`timescale 1ns/1ps
module can_bus_model (
    input  wire logic i_clock,
    output logic      o_rx
);
    // ----------------------------------------
    // Bus level
    // ----------------------------------------
    // The bus is pulled recessive when no node drives it
    initial o_rx = 1'h1;

    // Changes only right after a clock edge, like a real node
    task automatic drive(input logic level);
        @(posedge i_clock);
        o_rx <= level;
    endtask
endmodule // can_bus_model

// ---- verification/can_bit_timing_config_tb_top.sv ----
`timescale 1ns/1ps
module can_bit_timing_config_tb_top;
    // ----------------------------------------
    // Signals and counters
    // ----------------------------------------
    localparam int TQ  = 4;
    localparam int NOM = 40;
    localparam int SJC = 8;
    logic        i_clock = 1'h0;
    logic        i_rst_b = 1'h0;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rx;
    logic [2:0]  pulses;
    logic        rxbit;
    int          n_fail   = 0;
    int          compares = 0;
    int          cyc      = 0;

    initial forever #2 i_clock = ~i_clock;
    always @(posedge i_clock) cyc <= cyc + 1;

    can_bit_timing_config dut (
        .i_clock(i_clock), .i_rst_b(i_rst_b), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_can_rx(rx),
        .o_quantum_tick(pulses[0]), .o_bit_start(pulses[1]),
        .o_sample_point(pulses[2]), .o_rx_bit(rxbit)
    );
    can_bus_model bus (.i_clock(i_clock), .o_rx(rx));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check32(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic check_cnt(input string what, input int lo, input int hi, input int got);
        compares++;
        if (got < lo || got > hi) begin
            n_fail++;
            $display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, hi, got);
        end
    endtask

    // Request stands until pready is seen high at a rising edge; the answer is taken there
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge i_clock);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge i_clock);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge i_clock);
            n++;
        end while (pready !== 1'h1 && n < 50);
        if (n >= 50) n_fail++;
        rd  = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
        logic [31:0] r;
        logic        g;
        apb(1'h1, a, d, r, g);
        check32("write error flag", {31'h0, e}, {31'h0, g});
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic e);
        logic [31:0] r;
        logic        g;
        apb(1'h0, a, 32'h0, r, g);
        check32("read error flag", {31'h0, e}, {31'h0, g});
        check32("read data", x, r);
    endtask

    // Sel: 0 quantum tick, 1 bit start, 2 sample point
    task automatic wait_pulse(input int sel, output int t);
        int n;
        n = 0;
        do begin
            @(posedge i_clock);
            #1;
            n++;
        end while (pulses[sel] !== 1'h1 && n < 2000);
        if (n >= 2000) n_fail++;
        t = cyc;
    endtask

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        int t0;
        int t1;
        int t2;
        psel    <= 1'h0;
        penable <= 1'h0;
        pwrite  <= 1'h0;
        paddr   <= 12'h000;
        pwdata  <= 32'h0;
        repeat (3) @(posedge i_clock);
        i_rst_b <= 1'h1;
        repeat (3) @(posedge i_clock);
        rd(can_bit_timing_pkg::CTRL_ADDR, 32'h1, 1'h0);
        rd(can_bit_timing_pkg::PRESCALE_JUMP_ADDR, 32'h0, 1'h0);
        rd(can_bit_timing_pkg::SEGMENTS_ADDR, 32'h0, 1'h0);
        rd(can_bit_timing_pkg::STAT_ADDR, 32'h3, 1'h0);
        rd(12'h020, 32'h0, 1'h1);
        $display("test reset_values done");

        // Jump width 1, prescaler 1, seg2 field 2, seg1 field 5, single sample
        wr(can_bit_timing_pkg::PRESCALE_JUMP_ADDR, 32'h41, 1'h0);
        wr(can_bit_timing_pkg::SEGMENTS_ADDR, 32'h25, 1'h0);
        rd(can_bit_timing_pkg::SEGMENTS_ADDR, 32'h25, 1'h0);
        wr(can_bit_timing_pkg::CTRL_ADDR, 32'h0, 1'h0);
        wr(can_bit_timing_pkg::PRESCALE_JUMP_ADDR, 32'hFF, 1'h1);
        rd(can_bit_timing_pkg::PRESCALE_JUMP_ADDR, 32'h41, 1'h0);
        $display("test config_lock done");

        wait_pulse(0, t0);
        wait_pulse(0, t1);
        check_cnt("quantum period", TQ, TQ, t1 - t0);
        wait_pulse(2, t0);
        wait_pulse(1, t1);
        wait_pulse(2, t2);
        check_cnt("second segment", 3 * TQ, 3 * TQ, t1 - t0);
        check_cnt("sync and first segment", 7 * TQ, 7 * TQ, t2 - t1);
        $display("test bit_timing done");

        // Falling edge early in the first segment lengthens that bit
        wait_pulse(1, t0);
        repeat (2 * TQ) @(posedge i_clock);
        bus.drive(1'h0);
        wait_pulse(1, t1);
        check_cnt("resynchronized bit", NOM + 1, NOM + SJC, t1 - t0);
        wait_pulse(2, t2);
        check32("sampled dominant", 32'h0, {31'h0, rxbit});
        wait_pulse(1, t2);
        check_cnt("bit without edge", NOM, NOM, t2 - t1);
        bus.drive(1'h1);
        wait_pulse(1, t0);
        check_cnt("bit with rising edge", NOM, NOM, t0 - t2);
        $display("test resync done");

        // Triple sampling suits slower buses with spikes
        wr(can_bit_timing_pkg::CTRL_ADDR, 32'h1, 1'h0);
        wr(can_bit_timing_pkg::SEGMENTS_ADDR, 32'hA5, 1'h0);
        wr(can_bit_timing_pkg::CTRL_ADDR, 32'h0, 1'h0);
        wait_pulse(1, t0);
        // Spike lands on the sampling tick itself, so a single sample would see it
        repeat (6 * TQ - 2) @(posedge i_clock);
        bus.drive(1'h0);
        repeat (TQ - 1) @(posedge i_clock);
        bus.drive(1'h1);
        // A one-quantum spike can hit only one of the three samples
        wait_pulse(2, t1);
        check32("spike filtered", 32'h1, {31'h0, rxbit});
        wait_pulse(2, t1);
        check32("spike filtered later", 32'h1, {31'h0, rxbit});
        bus.drive(1'h0);
        wait_pulse(2, t1);
        wait_pulse(2, t1);
        check32("triple dominant", 32'h0, {31'h0, rxbit});
        bus.drive(1'h1);
        $display("test sampling done");
        give_verdict();
    end

    // ----------------------------------------
    // Watchdog
    // ----------------------------------------
    // The tests need well under a thousand cycles; the 25000-cycle limit leaves a wide margin
    initial begin
        #100000;
        n_fail++;
        give_verdict();
    end
endmodule // can_bit_timing_config_tb_top
